// File: hdl/arpt_pkg.sv
// Constants for the autoreload PWM timer: register indices, fields, resets.
// Assumes a 32-bit AHB-Lite bus with one register per aligned word.
`default_nettype none

package arpt_pkg;

	localparam int CNT_W = 12;
	localparam logic [CNT_W-1:0] CNT_MAX = 12'hFFF;
	localparam logic [CNT_W-1:0] CNT_RESET = 12'h000;

	// Register indices; byte address is four times the index
	localparam logic [7:0] IDX_TIMER_CONTROL_STATUS = 8'h0D;
	localparam logic [7:0] IDX_COUNTER_HIGH = 8'h0E;
	localparam logic [7:0] IDX_COUNTER_LOW = 8'h0F;
	localparam logic [7:0] IDX_RELOAD_HIGH = 8'h10;
	localparam logic [7:0] IDX_RELOAD_LOW = 8'h11;
	localparam logic [7:0] IDX_PWM_OUTPUT_CONTROL = 8'h12;
	localparam logic [7:0] IDX_PWM_CONTROL_STATUS = 8'h13;
	localparam logic [7:0] IDX_DUTY_HIGH = 8'h17;
	localparam logic [7:0] IDX_DUTY_LOW = 8'h18;

	// timer_control_status fields
	localparam int CLK_SEL_LSB = 3;
	localparam int OVF_FLAG_BIT = 2;
	localparam int OVF_IE_BIT = 1;
	localparam int CMP_IE_BIT = 0;
	// pwm_control_status fields
	localparam int POLARITY_BIT = 1;
	localparam int CMP_FLAG_BIT = 0;
	// pwm_output_control field
	localparam int OUT_EN_BIT = 0;

	localparam logic [7:0] REG_RESET = 8'h00;
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic HRESP_OKAY = 1'b0;

	typedef enum logic [1:0] {
		ARPT_CLK_OFF,
		ARPT_CLK_TIMEBASE,
		ARPT_CLK_CPU,
		ARPT_CLK_RESERVED
	} arpt_clk_sel_t;

endpackage
`default_nettype wire

// File: hdl/arpt_tick_sel.sv
// Counter clock selection: makes one-cycle ticks from the chosen source.
// Assumes timebase_clock is an asynchronous level from outside this domain.
`default_nettype none
`timescale 1ns/1ps

module arpt_tick_sel
	import arpt_pkg::*;
(
	input  wire logic          hclk,
	input  wire logic          hresetn,
	input  wire logic          clk_en,
	input  wire logic          timebase_clock,
	input  wire arpt_clk_sel_t clk_sel,
	output logic               tick
);

	logic sync_a;
	logic sync_b;
	logic sync_prev;
	logic next_tick;

	always_comb begin
		case (clk_sel)
			ARPT_CLK_TIMEBASE: next_tick = sync_b & ~sync_prev;
			ARPT_CLK_CPU:      next_tick = 1'b1;
			ARPT_CLK_OFF:      next_tick = 1'b0;
			default:           next_tick = 1'b0;
		endcase
	end

	// Edge detect reads the second stage and its delayed copy, never the first
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sync_a    <= 1'b0;
			sync_b    <= 1'b0;
			sync_prev <= 1'b0;
			tick      <= 1'b0;
		end else if (clk_en) begin
			sync_a    <= timebase_clock;
			sync_b    <= sync_a;
			sync_prev <= sync_b;
			tick      <= next_tick;
		end
	end

endmodule // arpt_tick_sel
`default_nettype wire

// File: hdl/arpt_counter.sv
// Free-running up-counter that reloads from the reload value on overflow.
// Assumes tick is a one-cycle pulse on hclk.
`default_nettype none
`timescale 1ns/1ps

module arpt_counter
	import arpt_pkg::*;
(
	input  wire logic             hclk,
	input  wire logic             hresetn,
	input  wire logic             clk_en,
	input  wire logic             tick,
	input  wire logic [CNT_W-1:0] reload,
	output logic      [CNT_W-1:0] count,
	output logic                  moved,
	output logic                  wrapped
);

	logic [CNT_W-1:0] next_count;
	logic             next_wrapped;

	always_comb begin
		next_count   = count;
		next_wrapped = 1'b0;
		if (tick) begin
			if (count == CNT_MAX) begin
				next_count   = reload;
				next_wrapped = 1'b1;
			end else begin
				next_count = count + 12'h001;
			end
		end
	end

	// moved and wrapped line up with the new count
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			count   <= CNT_RESET;
			moved   <= 1'b0;
			wrapped <= 1'b0;
		end else if (clk_en) begin
			count   <= next_count;
			moved   <= tick;
			wrapped <= next_wrapped;
		end
	end

endmodule // arpt_counter
`default_nettype wire

// File: hdl/arpt_top.sv
// Autoreload PWM timer: AHB-Lite register slave, flags and PWM channel.
// Assumes a single AHB-Lite master; hreadyout is the bus hready.
// Bus transfers are not accepted while clk_en is low.
//
// Chosen here: register access over AHB-Lite.
`default_nettype none
`timescale 1ns/1ps

// Operation
// - Clock select: off, timebase, CPU clock
// - Overflow flag set on wrap from FFFh
// - Reading timer status clears overflow flag
// - Overflow flag lasts one counter clock
// - Overflow enable gates overflow request
// - Compare enable gates compare request
// - Read-only counter increments on each tick
// - Overflow reloads counter from reload value
// - Reload value sets the PWM period
// - Output enable picks PWM or compare
// - Polarity bit inverts PWM output
// - Compare flag on match, cleared on read
// - Output enable drives pin, else free
// - Overflow loads shadow duty, output high
// - Match drives PWM low until overflow
// - Compare mode uses new value at once
// - High duty write suspends compare until low
module arpt_top
	import arpt_pkg::*;
(
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        clk_en,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic      [31:0] hrdata,
	input  wire logic        timebase_clock,
	output logic             pwm_output,
	output logic             pwm_output_oe,
	output logic             overflow_irq,
	output logic             compare_irq
);

	////////////////////////////////////////////////////////////////////////
	// Register state

	arpt_clk_sel_t    clk_sel;
	logic             overflow_irq_enable;
	logic             compare_irq_enable;
	logic             overflow_flag;
	logic [CNT_W-1:0] reload_value;
	logic             pwm_output_enable;
	logic             output_polarity;
	logic             compare_match_flag;
	logic [CNT_W-1:0] duty_compare_value;
	logic [CNT_W-1:0] duty_shadow;
	logic             compare_locked;
	logic             pwm_level;
	logic             wr_pend;
	logic [7:0]       wr_idx;

	arpt_clk_sel_t    next_clk_sel;
	logic             next_overflow_irq_enable;
	logic             next_compare_irq_enable;
	logic             next_overflow_flag;
	logic [CNT_W-1:0] next_reload_value;
	logic             next_pwm_output_enable;
	logic             next_output_polarity;
	logic             next_compare_match_flag;
	logic [CNT_W-1:0] next_duty_compare_value;
	logic [CNT_W-1:0] next_duty_shadow;
	logic             next_compare_locked;
	logic             next_pwm_level;
	logic             next_wr_pend;
	logic [7:0]       next_wr_idx;
	logic [31:0]      next_hrdata;
	logic             next_pwm_output;
	logic             next_pwm_output_oe;
	logic             next_overflow_irq;
	logic             next_compare_irq;

	logic             tick;
	logic [CNT_W-1:0] counter_value;
	logic             moved;
	logic             wrapped;

	logic             addr_ok;
	logic             rd_take;
	logic             wr_take;
	logic [7:0]       rd_idx;
	logic [7:0]       wbyte;
	logic [CNT_W-1:0] cmp_ref;
	logic             match_evt;

	////////////////////////////////////////////////////////////////////////
	// Submodules

	arpt_tick_sel u_tick_sel (
		.hclk           (hclk),
		.hresetn        (hresetn),
		.clk_en         (clk_en),
		.timebase_clock (timebase_clock),
		.clk_sel        (clk_sel),
		.tick           (tick)
	);

	arpt_counter u_counter (
		.hclk    (hclk),
		.hresetn (hresetn),
		.clk_en  (clk_en),
		.tick    (tick),
		.reload  (reload_value),
		.count   (counter_value),
		.moved   (moved),
		.wrapped (wrapped)
	);

	////////////////////////////////////////////////////////////////////////
	// Bus decode

	function automatic logic [7:0] word_index(input logic [31:0] addr);
		word_index = addr[9:2];
	endfunction

	// Anything above the mapped window ignores writes; a read there is not taken and hrdata keeps its last value
	assign addr_ok = (haddr[31:10] == 22'h000000);
	assign rd_idx  = word_index(haddr);
	assign rd_take = hsel & hready & (htrans == HTRANS_NONSEQ) & ~hwrite & addr_ok;
	assign wr_take = hsel & hready & (htrans == HTRANS_NONSEQ) & hwrite & addr_ok;
	assign wbyte   = hwdata[7:0];

	function automatic logic [7:0] read_mux(
		input logic [7:0] idx,
		input logic [7:0] tcs,
		input logic [7:0] pcs,
		input logic [CNT_W-1:0] cnt,
		input logic [CNT_W-1:0] rld,
		input logic [CNT_W-1:0] duty,
		input logic oe
	);
		read_mux = 8'h00;
		case (idx)
			IDX_TIMER_CONTROL_STATUS: read_mux = tcs;
			IDX_COUNTER_HIGH:         read_mux = {4'h0, cnt[11:8]};
			IDX_COUNTER_LOW:          read_mux = cnt[7:0];
			IDX_RELOAD_HIGH:          read_mux = {4'h0, rld[11:8]};
			IDX_RELOAD_LOW:           read_mux = rld[7:0];
			IDX_PWM_OUTPUT_CONTROL:   read_mux = {7'h00, oe};
			IDX_PWM_CONTROL_STATUS:   read_mux = pcs;
			IDX_DUTY_HIGH:            read_mux = {4'h0, duty[11:8]};
			IDX_DUTY_LOW:             read_mux = duty[7:0];
			default:                  read_mux = 8'h00;
		endcase
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Compare source and match

	always_comb begin
		cmp_ref = pwm_output_enable ? duty_shadow : duty_compare_value;
		// A zero value never compares
		match_evt = moved & ~compare_locked & (cmp_ref != CNT_RESET)
			& (counter_value == cmp_ref);
	end

	////////////////////////////////////////////////////////////////////////
	// Next-state logic

	always_comb begin
		logic [7:0] tcs;
		logic [7:0] pcs;
		tcs = REG_RESET;
		pcs = REG_RESET;
		tcs[CLK_SEL_LSB +: 2] = clk_sel;
		tcs[OVF_FLAG_BIT]     = overflow_flag;
		tcs[OVF_IE_BIT]       = overflow_irq_enable;
		tcs[CMP_IE_BIT]       = compare_irq_enable;
		pcs[POLARITY_BIT]     = output_polarity;
		pcs[CMP_FLAG_BIT]     = compare_match_flag;

		next_clk_sel             = clk_sel;
		next_overflow_irq_enable = overflow_irq_enable;
		next_compare_irq_enable  = compare_irq_enable;
		next_reload_value        = reload_value;
		next_pwm_output_enable   = pwm_output_enable;
		next_output_polarity     = output_polarity;
		next_duty_compare_value  = duty_compare_value;
		next_compare_locked      = compare_locked;
		next_duty_shadow         = duty_shadow;
		next_pwm_level           = pwm_level;
		next_wr_pend             = wr_take;
		next_wr_idx              = wr_take ? rd_idx : wr_idx;
		next_hrdata              = hrdata;

		// Data phase of a write
		if (wr_pend) begin
			case (wr_idx)
				IDX_TIMER_CONTROL_STATUS: begin
					next_clk_sel             = arpt_clk_sel_t'(wbyte[CLK_SEL_LSB +: 2]);
					next_overflow_irq_enable = wbyte[OVF_IE_BIT];
					next_compare_irq_enable  = wbyte[CMP_IE_BIT];
				end
				IDX_RELOAD_HIGH: next_reload_value[11:8] = wbyte[3:0];
				IDX_RELOAD_LOW:  next_reload_value[7:0]  = wbyte;
				IDX_PWM_OUTPUT_CONTROL: next_pwm_output_enable = wbyte[OUT_EN_BIT];
				IDX_PWM_CONTROL_STATUS: next_output_polarity = wbyte[POLARITY_BIT];
				IDX_DUTY_HIGH: begin
					next_duty_compare_value[11:8] = wbyte[3:0];
					next_compare_locked           = 1'b1;
				end
				IDX_DUTY_LOW: begin
					next_duty_compare_value[7:0] = wbyte;
					next_compare_locked          = 1'b0;
				end
				default: begin
				end
			endcase
		end

		// Address phase of a read: data is ready in the data phase
		if (rd_take) begin
			next_hrdata = {24'h000000,
				read_mux(rd_idx, tcs, pcs, counter_value, reload_value,
					duty_compare_value, pwm_output_enable)};
		end

		// Overflow flag lives one counter clock; a new wrap beats any clear
		if (wrapped) begin
			next_overflow_flag = 1'b1;
		end else if (moved) begin
			next_overflow_flag = 1'b0;
		end else if (rd_take && rd_idx == IDX_TIMER_CONTROL_STATUS) begin
			next_overflow_flag = 1'b0;
		end else begin
			next_overflow_flag = overflow_flag;
		end

		if (match_evt) begin
			next_compare_match_flag = 1'b1;
		end else if (rd_take && rd_idx == IDX_PWM_CONTROL_STATUS) begin
			next_compare_match_flag = 1'b0;
		end else begin
			next_compare_match_flag = compare_match_flag;
		end

		// Shadow takes the duty even if only the high byte is new
		if (wrapped) begin
			next_duty_shadow = duty_compare_value;
			next_pwm_level   = 1'b1;
		end
		// Match after the wrap in one cycle gives a flat low output
		if (match_evt && pwm_output_enable) begin
			next_pwm_level = 1'b0;
		end

		next_pwm_output    = pwm_output_enable & (next_pwm_level ^ output_polarity);
		next_pwm_output_oe = pwm_output_enable;
		next_overflow_irq  = next_overflow_flag & overflow_irq_enable;
		next_compare_irq   = next_compare_match_flag & compare_irq_enable;
	end

	////////////////////////////////////////////////////////////////////////
	// Registers

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			clk_sel             <= ARPT_CLK_OFF;
			overflow_irq_enable <= 1'b0;
			compare_irq_enable  <= 1'b0;
			overflow_flag       <= 1'b0;
			reload_value        <= CNT_RESET;
			pwm_output_enable   <= 1'b0;
			output_polarity     <= 1'b0;
			compare_match_flag  <= 1'b0;
			duty_compare_value  <= CNT_RESET;
			duty_shadow         <= CNT_RESET;
			compare_locked      <= 1'b0;
			pwm_level           <= 1'b0;
			wr_pend             <= 1'b0;
			wr_idx              <= 8'h00;
			hrdata              <= 32'h00000000;
			hreadyout           <= 1'b1;
			hresp               <= HRESP_OKAY;
			pwm_output          <= 1'b0;
			pwm_output_oe       <= 1'b0;
			overflow_irq        <= 1'b0;
			compare_irq         <= 1'b0;
		end else if (clk_en) begin
			clk_sel             <= next_clk_sel;
			overflow_irq_enable <= next_overflow_irq_enable;
			compare_irq_enable  <= next_compare_irq_enable;
			overflow_flag       <= next_overflow_flag;
			reload_value        <= next_reload_value;
			pwm_output_enable   <= next_pwm_output_enable;
			output_polarity     <= next_output_polarity;
			compare_match_flag  <= next_compare_match_flag;
			duty_compare_value  <= next_duty_compare_value;
			duty_shadow         <= next_duty_shadow;
			compare_locked      <= next_compare_locked;
			pwm_level           <= next_pwm_level;
			wr_pend             <= next_wr_pend;
			wr_idx              <= next_wr_idx;
			hrdata              <= next_hrdata;
			hreadyout           <= 1'b1;
			hresp               <= HRESP_OKAY;
			pwm_output          <= next_pwm_output;
			pwm_output_oe       <= next_pwm_output_oe;
			overflow_irq        <= next_overflow_irq;
			compare_irq         <= next_compare_irq;
		end
	end

	// hsize is not checked: every register answers any width as one word
	logic unused_ok;
	assign unused_ok = &{1'b0, hsize, hwdata[31:8]};

endmodule // arpt_top
`default_nettype wire

// File: tb/arpt_checker.sv
// Port-level assertions for the autoreload PWM timer.
// Assumes it is bound to arpt_top and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module arpt_checker
	import arpt_pkg::*;
(
	input wire logic        hclk,
	input wire logic        hresetn,
	input wire logic        hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic [31:0] hwdata,
	input wire logic        hready,
	input wire logic        hreadyout,
	input wire logic        hresp,
	input wire logic [31:0] hrdata,
	input wire logic        pwm_output,
	input wire logic        pwm_output_oe,
	input wire logic        overflow_irq,
	input wire logic        compare_irq
);
	logic             rd_q;
	logic             wr_q;
	logic [7:0]       a_q;
	logic [1:0]       sel;
	logic             oie;
	logic             cie;
	logic             oe;
	logic [CNT_W-1:0] rld;
	logic [3:0]       idle;
	////////////////////////////////////////////////////////////////
	// Shadow of the control bits, snooped from bus writes
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rd_q <= 1'b0;
			wr_q <= 1'b0;
			a_q <= 8'h00;
			sel <= 2'h0;
			oie <= 1'b0;
			cie <= 1'b0;
			oe <= 1'b0;
			rld <= 12'h000;
			idle <= 4'h0;
		end else begin
			rd_q <= hsel && hready && htrans == HTRANS_NONSEQ && !hwrite;
			wr_q <= hsel && hready && htrans == HTRANS_NONSEQ && hwrite;
			a_q <= haddr[9:2];
			if (wr_q && a_q == IDX_TIMER_CONTROL_STATUS) begin
				sel <= hwdata[4:3];
				oie <= hwdata[1];
				cie <= hwdata[0];
			end
			if (wr_q && a_q == IDX_PWM_OUTPUT_CONTROL)
				oe <= hwdata[0];
			if (wr_q && a_q == IDX_RELOAD_HIGH)
				rld[11:8] <= hwdata[3:0];
			if (wr_q && a_q == IDX_RELOAD_LOW)
				rld[7:0] <= hwdata[7:0];
			// Saturates; ticks in flight need a few cycles to drain
			idle <= (sel == 2'h0 || sel == 2'h3) ? ((idle == 4'hF) ? idle : idle + 4'h1) : 4'h0;
		end
	end
	////////////////////////////////////////////////////////////////
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	a_bus_okay: assert property (hreadyout && hresp == HRESP_OKAY)
		else $error("bus slave stalled or errored");
	a_rdata_upper: assert property (rd_q |-> hrdata[31:8] == 24'h0)
		else $error("read data upper bits not zero");
	a_cnt_high_nib: assert property (
		rd_q && a_q == IDX_COUNTER_HIGH |-> hrdata[7:4] == 4'h0)
		else $error("counter high byte has bits above 11");
	a_ovf_gated: assert property (overflow_irq |-> $past(oie))
		else $error("overflow request while disabled");
	a_cmp_gated: assert property (compare_irq |-> $past(cie))
		else $error("compare request while disabled");
	a_oe_follows: assert property (pwm_output_oe == $past(oe))
		else $error("pin enable does not follow its bit");
	a_pin_low_off: assert property (
		!pwm_output_oe && $past(!pwm_output_oe) |-> !pwm_output)
		else $error("pin driven while output disabled");
	a_ovf_one_tick: assert property (
		sel == 2'h2 && $past(sel) == 2'h2 && rld != CNT_MAX && overflow_irq |=> !overflow_irq)
		else $error("overflow held past one counter clock");
	a_stopped_quiet: assert property (
		idle >= 4'h8 && $stable(oie) |-> !$rose(overflow_irq))
		else $error("overflow while counter clock off");
endmodule // arpt_checker
`default_nettype wire

// File: tb/arpt_pwm_load.sv
// Load on the PWM pin: measures period and high time of the pin level.
// Assumes the pin has a pull-down when the timer releases it.
`timescale 1ns/1ps
`default_nettype none
module arpt_pwm_load (
	input  wire logic        hclk,
	input  wire logic        pwm_output,
	input  wire logic        pwm_output_oe,
	output logic      [15:0] high_len,
	output logic      [15:0] period
);
	logic        pin;
	logic        pin_q;
	logic [15:0] hc;
	logic [15:0] pc;
	assign pin = pwm_output_oe ? pwm_output : 1'b0;
	always_ff @(posedge hclk) begin
		pin_q <= pin;
		if (pin && !pin_q) begin
			period <= pc;
			pc <= 16'h0001;
			hc <= 16'h0001;
		end else begin
			pc <= pc + 16'h0001;
			if (pin)
				hc <= hc + 16'h0001;
		end
		if (!pin && pin_q)
			high_len <= hc;
	end
endmodule // arpt_pwm_load
`default_nettype wire

// File: tb/arpt_top_tb.sv
// Self-checking bench for the autoreload PWM timer over AHB-Lite.
// Assumes arpt_pkg is compiled first; the timebase pin is driven here.
`timescale 1ns/1ps
`default_nettype none
module arpt_top_tb
	import arpt_pkg::*;
;
	logic        hclk;
	logic        hresetn;
	logic        clk_en;
	logic        hsel;
	logic        hwrite;
	logic        timebase_clock;
	logic [1:0]  htrans;
	logic [31:0] haddr;
	logic [31:0] hwdata;
	logic [31:0] hrdata;
	logic [31:0] rd;
	logic        hreadyout;
	logic        hresp;
	logic        pwm_output;
	logic        pwm_output_oe;
	logic        overflow_irq;
	logic        compare_irq;
	logic [15:0] high_len;
	logic [15:0] period;
	int          num_errors = 0;
	int          check_count = 0;
	arpt_top arpt_top_inst (.hclk(hclk), .hresetn(hresetn), .clk_en(clk_en), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.timebase_clock(timebase_clock), .pwm_output(pwm_output),
		.pwm_output_oe(pwm_output_oe), .overflow_irq(overflow_irq), .compare_irq(compare_irq));
	arpt_pwm_load arpt_pwm_load_inst (.hclk(hclk), .pwm_output(pwm_output),
		.pwm_output_oe(pwm_output_oe), .high_len(high_len), .period(period));
	initial begin
		hclk = 1'b0;
		forever #2.5 hclk = ~hclk;
	end
	////////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			num_errors++;
			$display("wrong value at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask
	task automatic xfer(input logic w, input logic [7:0] idx, input logic [7:0] wd);
		@(posedge hclk);
		hsel <= 1'b1;
		hwrite <= w;
		htrans <= HTRANS_NONSEQ;
		haddr <= {22'h0, idx, 2'h0};
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= {24'h0, wd};
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask
	task automatic wr(input logic [7:0] idx, input logic [7:0] d);
		xfer(1'b1, idx, d);
	endtask
	task automatic rdchk(input logic [7:0] idx, input logic [7:0] exp);
		xfer(1'b0, idx, 8'h00);
		chk(rd, {24'h0, exp});
	endtask
	// Slow timebase pulses; tail lets the synchroniser settle
	task automatic tick(input int n);
		repeat (n) begin
			timebase_clock <= 1'b1;
			repeat (4) @(posedge hclk);
			timebase_clock <= 1'b0;
			repeat (4) @(posedge hclk);
		end
		repeat (4) @(posedge hclk);
	endtask
	////////////////////////////////////////////////////////////////
	task automatic t_regs;
		logic [7:0] idxs [10];
		idxs = '{IDX_TIMER_CONTROL_STATUS, IDX_COUNTER_HIGH, IDX_COUNTER_LOW, IDX_RELOAD_HIGH,
			IDX_RELOAD_LOW, IDX_PWM_OUTPUT_CONTROL, IDX_PWM_CONTROL_STATUS, IDX_DUTY_HIGH,
			IDX_DUTY_LOW, 8'h20};
		foreach (idxs[i]) rdchk(idxs[i], REG_RESET);
		wr(IDX_COUNTER_LOW, 8'hAA);
		wr(8'h20, 8'h55);
		rdchk(IDX_COUNTER_LOW, 8'h00);
		rdchk(8'h20, 8'h00);
	endtask
	task automatic t_overflow;
		int n;
		wr(IDX_RELOAD_HIGH, 8'h0F);
		wr(IDX_RELOAD_LOW, 8'hF0);
		wr(IDX_TIMER_CONTROL_STATUS, 8'h13);
		n = 0;
		while (overflow_irq !== 1'b1 && n < 5000) begin
			@(posedge hclk);
			n++;
		end
		n = 0;
		do begin
			@(posedge hclk);
			n++;
		end while (overflow_irq !== 1'b1 && n < 100);
		chk(n, 16);
		wr(IDX_TIMER_CONTROL_STATUS, 8'h0B);
		n = 0;
		while (overflow_irq !== 1'b1 && n < 20) begin
			tick(1);
			n++;
		end
		rdchk(IDX_TIMER_CONTROL_STATUS, 8'h0F);
		rdchk(IDX_TIMER_CONTROL_STATUS, 8'h0B);
		chk(overflow_irq, 1'b0);
		rdchk(IDX_COUNTER_HIGH, 8'h0F);
		rdchk(IDX_COUNTER_LOW, 8'hF0);
		tick(17);
		rdchk(IDX_TIMER_CONTROL_STATUS, 8'h0B);
		rdchk(IDX_COUNTER_LOW, 8'hF1);
	endtask
	task automatic t_stop;
		wr(IDX_TIMER_CONTROL_STATUS, 8'h03);
		tick(3);
		rdchk(IDX_COUNTER_LOW, 8'hF1);
		wr(IDX_TIMER_CONTROL_STATUS, 8'h1B);
		tick(3);
		rdchk(IDX_COUNTER_LOW, 8'hF1);
		rdchk(IDX_TIMER_CONTROL_STATUS, 8'h1B);
		// Frozen clock enable must swallow timebase edges
		wr(IDX_TIMER_CONTROL_STATUS, 8'h0B);
		clk_en <= 1'b0;
		tick(3);
		clk_en <= 1'b1;
		rdchk(IDX_COUNTER_LOW, 8'hF1);
	endtask
	task automatic t_compare;
		wr(IDX_TIMER_CONTROL_STATUS, 8'h0B);
		wr(IDX_DUTY_HIGH, 8'h0F);
		wr(IDX_DUTY_LOW, 8'hF3);
		tick(2);
		chk(compare_irq, 1'b1);
		rdchk(IDX_PWM_CONTROL_STATUS, 8'h01);
		rdchk(IDX_PWM_CONTROL_STATUS, 8'h00);
		wr(IDX_DUTY_HIGH, 8'h0F);
		wr(IDX_DUTY_LOW, 8'hF6);
		wr(IDX_DUTY_HIGH, 8'h0F);
		tick(3);
		rdchk(IDX_PWM_CONTROL_STATUS, 8'h00);
		wr(IDX_DUTY_LOW, 8'hF8);
		tick(2);
		rdchk(IDX_PWM_CONTROL_STATUS, 8'h01);
	endtask
	task automatic t_pwm;
		wr(IDX_DUTY_HIGH, 8'h0F);
		wr(IDX_DUTY_LOW, 8'hFC);
		wr(IDX_PWM_OUTPUT_CONTROL, 8'h01);
		wr(IDX_TIMER_CONTROL_STATUS, 8'h13);
		repeat (64) @(posedge hclk);
		chk(period, 16);
		chk(high_len, 12);
		wr(IDX_PWM_CONTROL_STATUS, 8'h02);
		repeat (64) @(posedge hclk);
		chk(high_len, 4);
		wr(IDX_PWM_OUTPUT_CONTROL, 8'h00);
		repeat (4) @(posedge hclk);
		chk({pwm_output_oe, pwm_output}, 2'b00);
	endtask
	// Mid-run reset while the counter runs at CPU clock
	task automatic t_reset;
		@(posedge hclk);
		hresetn <= 1'b0;
		repeat (2) @(posedge hclk);
		chk({hreadyout, pwm_output_oe, pwm_output, overflow_irq, compare_irq}, 5'b10000);
		hresetn <= 1'b1;
		rdchk(IDX_TIMER_CONTROL_STATUS, REG_RESET);
		rdchk(IDX_COUNTER_LOW, REG_RESET);
		rdchk(IDX_PWM_CONTROL_STATUS, REG_RESET);
		rdchk(IDX_RELOAD_LOW, REG_RESET);
		rdchk(IDX_DUTY_LOW, REG_RESET);
	endtask
	////////////////////////////////////////////////////////////////
	task automatic tally_and_finish;
		$display("checks %0d, errors %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	initial begin
		hresetn = 1'b0;
		clk_en = 1'b1;
		hsel = 1'b0;
		hwrite = 1'b0;
		htrans = 2'h0;
		haddr = 32'h0;
		hwdata = 32'h0;
		timebase_clock = 1'b0;
		repeat (8) @(posedge hclk);
		hresetn <= 1'b1;
		t_regs;
		t_overflow;
		t_stop;
		t_compare;
		t_pwm;
		t_reset;
		tally_and_finish;
	end
	// Whole run needs well under 8000 cycles
	initial begin
		repeat (20000) @(posedge hclk);
		num_errors++;
		tally_and_finish;
	end
endmodule // arpt_top_tb
bind arpt_top arpt_checker arpt_checker_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
	.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
	.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .pwm_output(pwm_output),
	.pwm_output_oe(pwm_output_oe), .overflow_irq(overflow_irq), .compare_irq(compare_irq));
`default_nettype wire
